// *** src/bec_regs.svh ***
// constant names for the bus event comparator groups
// How it works
// - address comparator matches exact value, outer range with endpoints, inner without
// - a range without explicit type is compared as inner range
// - address compares use 24 bits, or 32 bits with wide option
// - wide option splits 32-bit patterns over two comparators and ANDs them
// - only addresses actually driven on the bus are compared
// - data comparator holds 16-bit value and don't-care mask; set bits ignored
// - data masking works on single bits, not only nibbles
// - status bit 14 is interrupt pending, bit 13 is autovector
// - status bits 11..9 interrupt level, bit 8 bus fault
// - status bits 6..4 hold the address space code
// - status bit 2 set for user hardware, clear for emulator memory
// - status bit 1 read when set, bit 0 byte when set
// - a combined status pattern is true only when all attributes hold
// - probe inputs are caught at each bus cycle end and compared
// - probe comparator is 16 bits with per-bit don't-care mask
// - count limits are 16-bit values from 1 up to FFFF
// - counter drops by one per count action; zero makes limit true
// - counter value is hidden; only reaching zero is visible
// - one shared counter, four limits; run entry loads group one limit
// - four groups, each with its own comparators and statements
// - statements of a group are evaluated only while that group is active
// - patterns are copied into the comparators at run start only
// - every run entry starts in group one
// - group change keeps the count unless reload comes with it
// - negation binds tightest, then conjunction, then disjunction
`ifndef BEC_REGS_SVH
`define BEC_REGS_SVH
// ---------------------------------------------------------------
// configuration word layout within one group
// ---------------------------------------------------------------
`define BEC_F_ADR1_LO   4'h0
`define BEC_F_ADR1_HI   4'h1
`define BEC_F_ADR1_MODE 4'h2
`define BEC_F_ADR2_LO   4'h3
`define BEC_F_ADR2_HI   4'h4
`define BEC_F_ADR2_MODE 4'h5
`define BEC_F_DAT1      4'h6
`define BEC_F_DAT2      4'h7
`define BEC_F_ST1      4'h8
`define BEC_F_ST2      4'h9
`define BEC_F_PRB      4'hA
`define BEC_F_LIMIT    4'hB
`define BEC_F_STMT0    4'hC
`define BEC_F_STMT1    4'hD
`define BEC_LAST_WORD  6'h3F
// ---------------------------------------------------------------
// address modes, status bit positions, misc
// ---------------------------------------------------------------
`define BEC_AM_EXACT   2'h0
`define BEC_AM_RANGE   2'h1
`define BEC_AM_INNER   2'h2
`define BEC_AM_OUTER   2'h3
`define BEC_NARROW_MSK 32'h00FFFFFF
`define BEC_SB_IRQ     14
`define BEC_SB_AVEC    13
`define BEC_SB_IPL     9
`define BEC_SB_BF      8
`define BEC_SB_SPACE   4
`define BEC_SB_UHW     2
`define BEC_SB_RD      1
`define BEC_SB_BYTE    0
`define BEC_GROUP_ONE  2'h0
`define BEC_CNT_RST    16'h0000
`endif

// *** src/bec_pkg.sv ***
// types shared by the bus event comparator groups
package bec_pkg;
  // one sampled processor bus cycle as seen on the pins
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic        interrupt_pending;
    logic        autovector_flag;
    logic [2:0]  int_level;
    logic        bus_fault_flag;
    logic [2:0]  space_code_field;
    logic        user_hardware_access;
    logic        read_access;
    logic        single_byte_access;
    logic [15:0] probe;
  } bec_bus_s;

  // pattern load from control software
  typedef struct packed {
    logic        we;
    logic [1:0]  group;
    logic [3:0]  field;
    logic [31:0] data;
  } bec_cfg_wr_s;

  typedef enum logic [1:0] {
    BEC_IDLE = 2'b00,
    BEC_COPY = 2'b01,
    BEC_ARM  = 2'b10,
    BEC_RUN  = 2'b11
  } bec_state_e;
endpackage

// *** src/bec_cfg_mem.sv ***
// pattern store written by software and read back by the copy engine
`timescale 1ns/1ps
module bec_cfg_mem #(
  parameter int AW = 6,
  parameter int DW = 32
) (
  input  wire logic          sys_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write port, no reset: contents only matter once software loaded them
  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // registered read
  always_ff @(posedge sys_clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule

// *** src/bec_counter.sv ***
// shared event counter with saturating decrement
`timescale 1ns/1ps
`include "bec_regs.svh"
module bec_counter #(
  parameter int W = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         dec_i,
  output logic              zero_o
);
  logic [W-1:0] cnt;

  // load wins over decrement; value never leaves this module
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt <= `BEC_CNT_RST;
    end else if (load_i) begin
      cnt <= load_val_i; // a zero limit is illegal, loads as already true
    end else if (dec_i && (cnt != '0)) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign zero_o = (cnt == '0);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  count_step_a: assert property (dec_i && !load_i && cnt != '0 |=> cnt == $past(cnt) - 1'b1)
    else $error("counter did not step down by one");
  count_stick_a: assert property (zero_o && !load_i |=> zero_o)
    else $error("counter left zero without reload");
  count_load_a: assert property (load_i |=> cnt == $past(load_val_i))
    else $error("counter load value lost");
endmodule

// *** src/bec_top.sv ***
// bus cycle event recognition: comparator groups, sequencer, shared counter
`timescale 1ns/1ps
`include "bec_regs.svh"
module bec_top #(
  parameter int NGRP_W = 2,
  parameter int FLD_W  = 4
) (
  input  wire logic                sys_clk_i,
  input  wire logic                nrst_i,
  input  wire bec_pkg::bec_bus_s   bus_i,
  input  wire logic                bus_end_i,
  input  wire bec_pkg::bec_cfg_wr_s cfg_i,
  input  wire logic                run_i,
  input  wire logic                wide_i,
  input  wire logic                count_i,
  input  wire logic                reload_i,
  input  wire logic                group_switch_i,
  input  wire logic [1:0]          new_group_i,
  output logic [7:0]               cond_o,
  output logic [1:0]               stmt_hit_o,
  output logic [1:0]               group_o,
  output logic                     armed_o
);
  localparam int IW = NGRP_W + FLD_W;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // masked compare: set mask bits are don't care
  function automatic logic masked_hit(input logic [15:0] v, input logic [15:0] ref_v,
                                      input logic [15:0] dc);
    masked_hit = (((v ^ ref_v) & ~dc) == 16'h0000);
  endfunction

  // exact or range compare on 24 or 32 address bits
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi, input logic [1:0] mode,
                                    input logic wide);
    logic [31:0] m;
    logic [31:0] am;
    logic [31:0] lm;
    logic [31:0] hm;
    m  = wide ? 32'hFFFFFFFF : `BEC_NARROW_MSK;
    am = a & m;
    lm = lo & m;
    hm = hi & m;
    case (mode)
      `BEC_AM_EXACT: addr_hit = (am == lm);
      `BEC_AM_OUTER: addr_hit = (am >= lm) && (am <= hm);
      default:       addr_hit = (am > lm) && (am < hm);
    endcase
  endfunction

  // sum of two product terms: use selects conditions, inv negates them first
  function automatic logic stmt_eval(input logic [7:0] c, input logic [31:0] w);
    logic t0;
    logic t1;
    t0 = (w[7:0] != 8'h00) && ((((c ^ w[15:8]) & w[7:0])) == w[7:0]);
    t1 = (w[23:16] != 8'h00) && ((((c ^ w[31:24]) & w[23:16])) == w[23:16]);
    stmt_eval = t0 | t1;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  bec_pkg::bec_bus_s bus_s1;
  bec_pkg::bec_bus_s bus_s2;
  logic              end_s1;
  logic              end_s2;
  logic              end_s3;
  logic              bus_end;

  // bus pins are sampled as a word; the cycle end strobe is delayed the same,
  // so the bus must stay stable a few clocks around the trailing edge
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      bus_s1 <= '0;
      bus_s2 <= '0;
      end_s1 <= 1'b0;
      end_s2 <= 1'b0;
      end_s3 <= 1'b0;
    end else begin
      bus_s1 <= bus_i;
      bus_s2 <= bus_s1;
      end_s1 <= bus_end_i;
      end_s2 <= end_s1;
      end_s3 <= end_s2;
    end
  end

  assign bus_end = end_s2 && !end_s3;

  // probe latch at the trailing edge of each cycle
  logic [15:0] probe_hold;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      probe_hold <= '0;
    end else if (bus_end) begin
      probe_hold <= bus_s2.probe;
    end
  end

  // status word assembled at the documented bit positions
  logic [15:0] status_word;
  always_comb begin
    status_word                               = 16'h0000;
    status_word[`BEC_SB_IRQ]                  = bus_s2.interrupt_pending;
    status_word[`BEC_SB_AVEC]                 = bus_s2.autovector_flag;
    status_word[`BEC_SB_IPL+2:`BEC_SB_IPL]    = bus_s2.int_level;
    status_word[`BEC_SB_BF]                   = bus_s2.bus_fault_flag;
    status_word[`BEC_SB_SPACE+2:`BEC_SB_SPACE] = bus_s2.space_code_field;
    status_word[`BEC_SB_UHW]                  = bus_s2.user_hardware_access;
    status_word[`BEC_SB_RD]                   = bus_s2.read_access;
    status_word[`BEC_SB_BYTE]                 = bus_s2.single_byte_access;
  end

  // ---------------------------------------------------------------
  // pattern store and copy into active comparators
  // ---------------------------------------------------------------
  bec_pkg::bec_state_e state;
  logic [IW-1:0]       rd_addr;
  logic [IW-1:0]       wr_idx;
  logic                rd_pend;
  logic [31:0]         rd_data;
  logic [31:0]         act [0:(1<<IW)-1];
  logic                run_q;
  logic                run_rise;

  bec_cfg_mem #(.AW(IW), .DW(32)) bec_cfg_mem_i (
    .sys_clk_i (sys_clk_i),
    .we_i      (cfg_i.we),
    .waddr_i   ({cfg_i.group, cfg_i.field}),
    .wdata_i   (cfg_i.data),
    .raddr_i   (rd_addr),
    .rdata_o   (rd_data)
  );

  assign run_rise = run_i && !run_q;

  // run state machine; a run drop aborts any copy in progress
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state   <= bec_pkg::BEC_IDLE;
      run_q   <= 1'b0;
      rd_addr <= '0;
      rd_pend <= 1'b0;
      wr_idx  <= '0;
    end else begin
      run_q   <= run_i;
      rd_pend <= (state == bec_pkg::BEC_COPY);
      wr_idx  <= rd_addr;
      case (state)
        bec_pkg::BEC_IDLE: begin
          rd_addr <= '0;
          if (run_rise) begin
            state <= bec_pkg::BEC_COPY;
          end
        end
        bec_pkg::BEC_COPY: begin
          rd_addr <= rd_addr + 1'b1;
          if (!run_i) begin
            state <= bec_pkg::BEC_IDLE;
          end else if (rd_addr == `BEC_LAST_WORD) begin
            state <= bec_pkg::BEC_ARM;
          end
        end
        bec_pkg::BEC_ARM: begin
          state <= run_i ? bec_pkg::BEC_RUN : bec_pkg::BEC_IDLE;
        end
        bec_pkg::BEC_RUN: begin
          if (!run_i) begin
            state <= bec_pkg::BEC_IDLE;
          end
        end
        default: state <= bec_pkg::BEC_IDLE;
      endcase
    end
  end

  // active comparator words change only while copying, never during a run
  always_ff @(posedge sys_clk_i) begin
    if (rd_pend) begin
      act[wr_idx] <= rd_data;
    end
  end

  // ---------------------------------------------------------------
  // group sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      group_o <= `BEC_GROUP_ONE;
    end else if (state != bec_pkg::BEC_RUN) begin
      group_o <= `BEC_GROUP_ONE;
    end else if (group_switch_i) begin
      group_o <= new_group_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      armed_o <= 1'b0;
    end else begin
      armed_o <= (state == bec_pkg::BEC_RUN) && run_i;
    end
  end

  // ---------------------------------------------------------------
  // shared counter
  // ---------------------------------------------------------------
  logic        cnt_load;
  logic [15:0] cnt_load_val;
  logic        cnt_zero;
  logic        running;

  assign running = (state == bec_pkg::BEC_RUN);

  // run start loads group one; reload with a switch takes the new group's limit
  always_comb begin
    cnt_load     = 1'b0;
    cnt_load_val = act[{`BEC_GROUP_ONE, `BEC_F_LIMIT}][15:0];
    if (state == bec_pkg::BEC_ARM) begin
      cnt_load = 1'b1;
    end else if (running && reload_i) begin
      cnt_load     = 1'b1;
      cnt_load_val = group_switch_i ? act[{new_group_i, `BEC_F_LIMIT}][15:0]
                                    : act[{group_o, `BEC_F_LIMIT}][15:0];
    end
  end

  bec_counter #(.W(16)) bec_counter_i (
    .sys_clk_i  (sys_clk_i),
    .nrst_i     (nrst_i),
    .load_i     (cnt_load),
    .load_val_i (cnt_load_val),
    .dec_i      (running && count_i),
    .zero_o     (cnt_zero)
  );

  // ---------------------------------------------------------------
  // comparators of the active group
  // ---------------------------------------------------------------
  logic [7:0]  next_cond;
  logic [IW-1:0] gb;
  logic [31:0] w_dat1;
  logic [31:0] w_dat2;
  logic        d1_lo;
  logic        d2_lo;
  logic        d1_hi;
  logic        d2_lo_w;

  assign gb    = {group_o, {FLD_W{1'b0}}};
  assign w_dat1  = act[gb | IW'(`BEC_F_DAT1)];
  assign w_dat2  = act[gb | IW'(`BEC_F_DAT2)];
  assign d1_lo   = masked_hit(bus_s2.data[15:0], w_dat1[15:0], w_dat1[31:16]);
  assign d2_lo   = masked_hit(bus_s2.data[15:0], w_dat2[15:0], w_dat2[31:16]);
  assign d1_hi   = masked_hit(bus_s2.data[31:16], w_dat1[15:0], w_dat1[31:16]);
  assign d2_lo_w = d2_lo;

  // address is compared only as driven in this cycle; fetches show aligned words
  always_comb begin
    next_cond[0] = addr_hit(bus_s2.addr, act[gb | IW'(`BEC_F_ADR1_LO)],
                            act[gb | IW'(`BEC_F_ADR1_HI)],
                            act[gb | IW'(`BEC_F_ADR1_MODE)][1:0], wide_i);
    next_cond[1] = addr_hit(bus_s2.addr, act[gb | IW'(`BEC_F_ADR2_LO)],
                            act[gb | IW'(`BEC_F_ADR2_HI)],
                            act[gb | IW'(`BEC_F_ADR2_MODE)][1:0], wide_i);
    // wide mode: upper half against the first, lower half against the second
    next_cond[2] = wide_i ? (d1_hi && d2_lo_w) : d1_lo;
    next_cond[3] = wide_i ? (d1_hi && d2_lo_w) : d2_lo;
    next_cond[4] = masked_hit(status_word, act[gb | IW'(`BEC_F_ST1)][15:0],
                              act[gb | IW'(`BEC_F_ST1)][31:16]);
    next_cond[5] = masked_hit(status_word, act[gb | IW'(`BEC_F_ST2)][15:0],
                              act[gb | IW'(`BEC_F_ST2)][31:16]);
    next_cond[6] = masked_hit(bus_s2.probe, act[gb | IW'(`BEC_F_PRB)][15:0],
                              act[gb | IW'(`BEC_F_PRB)][31:16]);
    next_cond[7] = cnt_zero;
  end

  // results held from one finished bus cycle to the next
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cond_o     <= '0;
      stmt_hit_o <= '0;
    end else if (!running) begin
      cond_o     <= '0;
      stmt_hit_o <= '0;
    end else if (bus_end) begin
      cond_o        <= next_cond;
      stmt_hit_o[0] <= stmt_eval(next_cond, act[gb | IW'(`BEC_F_STMT0)]);
      stmt_hit_o[1] <= stmt_eval(next_cond, act[gb | IW'(`BEC_F_STMT1)]);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  start_group_a: assert property (state == bec_pkg::BEC_ARM ##1 running |-> group_o == 2'h0)
    else $error("run did not start in group one");
  first_load_a: assert property (state == bec_pkg::BEC_ARM |-> cnt_load &&
      cnt_load_val == act[{`BEC_GROUP_ONE, `BEC_F_LIMIT}][15:0])
    else $error("run entry did not load group one limit");
  keep_count_a: assert property (running && group_switch_i && !reload_i |-> !cnt_load)
    else $error("group change disturbed the counter");
  switch_reload_a: assert property (running && group_switch_i && reload_i |->
      cnt_load_val == act[{new_group_i, `BEC_F_LIMIT}][15:0])
    else $error("reload on switch used wrong limit");
  cond_hold_a: assert property (running && !bus_end |=> $stable(cond_o))
    else $error("conditions changed without a bus cycle");
  probe_catch_a: assert property (bus_end |=> probe_hold == $past(bus_s2.probe))
    else $error("probe value not caught at cycle end");
  frozen_cfg_a: assert property (running && $past(running) |-> $stable(act[0]))
    else $error("active pattern changed during a run");
  idle_quiet_a: assert property (!running |=> stmt_hit_o == 2'b00)
    else $error("statement hit outside a run");
  group_follow_a: assert property (running && group_switch_i && run_i ##1 running |->
      group_o == $past(new_group_i))
    else $error("group did not follow the switch");

  switch_seen_c: cover property (running && group_switch_i && reload_i);
  limit_reached_c: cover property (running && bus_end && cnt_zero);
  stmt_fired_c: cover property (stmt_hit_o != 2'b00);
endmodule

// *** tb/bec_bus_model.sv ***
// target processor bus model: presents bus cycles to the comparator block
`timescale 1ns/1ps
module bec_bus_model (
  input  wire logic        sys_clk_i,
  output bec_pkg::bec_bus_s bus_o,
  output logic             bus_end_o
);
  // pins idle low before the first cycle
  initial begin
    bus_o     = '0;
    bus_end_o = 1'b0;
  end

  // pins a cycle (or more, when slow) ahead of the trailing edge, held 3+ after
  task automatic cycle(input bec_pkg::bec_bus_s b, input int slow);
    @(negedge sys_clk_i);
    bus_o = b;
    repeat (1 + slow) @(negedge sys_clk_i);
    bus_end_o = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    bus_end_o = 1'b0;
    bus_o     = ~b; // released pins must not keep the sampled value
    repeat (2) @(negedge sys_clk_i);
  endtask
endmodule

// *** tb/bec_top_test.sv ***
// self-checking bench for the bus event comparator groups
`timescale 1ns/1ps
module bec_top_test;
  logic                 sys_clk_i, nrst_i, bus_end_i, run_i, wide_i;
  logic                 count_i, reload_i, group_switch_i, armed_o;
  logic [1:0]           new_group_i, stmt_hit_o, group_o;
  logic [7:0]           cond_o;
  bec_pkg::bec_bus_s    bus_i, b;
  bec_pkg::bec_cfg_wr_s cfg_i;
  logic [31:0]          pend [4][16];
  logic [31:0]          shadow [4][16];
  logic [31:0]          a0;
  int                   miscompares, n_checks, cnt, grp, k;

  bec_top bec_top_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_i(bus_i),
    .bus_end_i(bus_end_i), .cfg_i(cfg_i), .run_i(run_i), .wide_i(wide_i), .count_i(count_i),
    .reload_i(reload_i), .group_switch_i(group_switch_i), .new_group_i(new_group_i),
    .cond_o(cond_o), .stmt_hit_o(stmt_hit_o), .group_o(group_o), .armed_o(armed_o));
  bec_bus_model bus_model_i (.sys_clk_i(sys_clk_i), .bus_o(bus_i), .bus_end_o(bus_end_i));

  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // ---------------------------------------------------------------
  // reference functions
  // ---------------------------------------------------------------
  function automatic logic mm(input logic [15:0] v, input logic [31:0] w);
    return ((v ^ w[15:0]) & ~w[31:16]) == 16'h0000;
  endfunction

  function automatic logic am(input logic [31:0] a, input int i);
    logic [31:0] m, lo, hi;
    m  = wide_i ? 32'hFFFFFFFF : 32'h00FFFFFF;
    a  = a & m;
    lo = shadow[grp][i] & m;
    hi = shadow[grp][i + 1] & m;
    case (shadow[grp][i + 2][1:0])
      2'h0: return a == lo;
      2'h3: return a >= lo && a <= hi;
      default: return a > lo && a < hi;
    endcase
  endfunction

  function automatic logic [7:0] exp_cond(input bec_pkg::bec_bus_s x);
    logic [15:0] s;
    logic [7:0]  c;
    s = {1'b0, x.interrupt_pending, x.autovector_flag, 1'b0, x.int_level, x.bus_fault_flag,
         1'b0, x.space_code_field, 1'b0, x.user_hardware_access, x.read_access,
         x.single_byte_access};
    c[0] = am(x.addr, 0);
    c[1] = am(x.addr, 3);
    c[2] = wide_i ? mm(x.data[31:16], shadow[grp][6]) && mm(x.data[15:0], shadow[grp][7])
                  : mm(x.data[15:0], shadow[grp][6]);
    c[3] = wide_i ? c[2] : mm(x.data[15:0], shadow[grp][7]);
    c[4] = mm(s, shadow[grp][8]);
    c[5] = mm(s, shadow[grp][9]);
    c[6] = mm(x.probe, shadow[grp][10]);
    c[7] = cnt == 0;
    return c;
  endfunction

  // two and-terms ored, inversion applied per used condition
  function automatic logic stmt(input logic [7:0] c, input int f);
    logic [31:0] w;
    w = shadow[grp][f];
    return (w[7:0] != 8'h00 && ((c ^ w[15:8]) & w[7:0]) == w[7:0]) ||
           (w[23:16] != 8'h00 && ((c ^ w[31:24]) & w[23:16]) == w[23:16]);
  endfunction

  // ---------------------------------------------------------------
  // drivers and comparison
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic wr(input int g, input int f, input logic [31:0] d);
    @(negedge sys_clk_i);
    cfg_i = '{we: 1'b1, group: g[1:0], field: f[3:0], data: d};
    pend[g][f] = d;
    @(negedge sys_clk_i);
    cfg_i.we = 1'b0;
  endtask

  // restart run mode; patterns in force from here on are the pending ones
  task automatic start_run();
    @(negedge sys_clk_i);
    run_i = 1'b0;
    @(negedge sys_clk_i);
    shadow = pend;
    run_i  = 1'b1;
    k      = 0;
    while (armed_o !== 1'b1 && k < 80) begin
      @(negedge sys_clk_i);
      k++;
    end
    check({7'h00, k >= 66 && k <= 68}, 8'h01, "arming time");
    check({6'h00, group_o}, 8'h00, "start group");
    grp = 0;
    cnt = shadow[0][11][15:0];
  endtask

  // biased random bus cycle so that comparators hit often
  task automatic rnd_cyc(input logic [31:0] a);
    logic [95:0] r;
    logic [7:0]  c;
    r = {$urandom, $urandom, $urandom};
    b = r[91:0];
    b.addr = wide_i ? a : {r[95:88], a[23:0]};
    if (r[92]) b.data[31:16] = shadow[grp][6][15:0] ^ (r[47:32] & shadow[grp][6][31:16]);
    if (r[93]) b.data[15:0] = shadow[grp][7][15:0] ^ (r[15:0] & shadow[grp][7][31:16]);
    if (r[94]) {b.space_code_field, b.read_access, b.single_byte_access} = 5'b01000;
    if (r[95]) b.probe = shadow[grp][10][15:0] ^ (r[63:48] & shadow[grp][10][31:16]);
    bus_model_i.cycle(b, int'(r[1:0]));
    c = exp_cond(b);
    check(cond_o, c, "conditions");
    check({6'h00, stmt_hit_o}, {6'h00, stmt(c, 13), stmt(c, 12)}, "statements");
  endtask

  task automatic count_n(input int n);
    repeat (n) begin
      @(negedge sys_clk_i);
      count_i = 1'b1;
      if (cnt > 0) cnt--;
    end
    @(negedge sys_clk_i);
    count_i = 1'b0;
  endtask

  task automatic act(input int g, input logic rl, input logic sw);
    @(negedge sys_clk_i);
    {reload_i, group_switch_i} = {rl, sw};
    new_group_i = g[1:0];
    @(negedge sys_clk_i);
    {reload_i, group_switch_i} = 2'b00;
    @(negedge sys_clk_i);
    if (sw) grp = g;
    if (rl) cnt = shadow[grp][11][15:0];
    check({6'h00, group_o}, {6'h00, grp[1:0]}, "group");
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs about two thousand cycles
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    miscompares++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {nrst_i, run_i, wide_i, count_i, reload_i, group_switch_i, new_group_i} = '0;
    cfg_i       = '0;
    miscompares = 0;
    n_checks    = 0;
    k           = $urandom(3);
    repeat (8) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    for (int g = 0; g < 4; g++) begin
      for (int f = 0; f < 16; f++) begin
        wr(g, f, (f == 11) ? 32'($urandom_range(1, 65535)) : $urandom);
      end
    end
    a0 = $urandom & 32'h00FFFFFC;
    wr(0, 0, a0);
    wr(0, 3, 32'h00001000);
    wr(0, 4, 32'h00001FFF);
    wr(0, 6, {16'h0005, 16'($urandom)});
    wr(0, 7, {16'h00F0, 16'($urandom)});
    wr(0, 8, 32'hFF8C0020);
    wr(0, 9, 32'hBFFF4000);
    wr(0, 10, {16'h0005, 16'($urandom)});
    wr(0, 11, 32'h00000003);
    wr(0, 12, 32'h00100405);
    wr(0, 13, 32'h00000080);
    // every address mode at both range ends
    for (int m = 0; m < 4; m++) begin
      wr(0, 5, m);
      start_run();
      for (int d = -1; d < 2; d++) begin
        rnd_cyc(32'h00001000 + d);
        rnd_cyc(32'h00001FFF + d);
      end
      rnd_cyc(a0);
    end
    repeat (40) rnd_cyc($urandom_range(0, 1) ? a0 : $urandom & 32'hFFFFFFFC);
    wide_i = 1'b1;
    start_run();
    repeat (30) rnd_cyc($urandom_range(0, 1) ? a0 : $urandom & 32'hFFFFFFFC);
    wide_i = 1'b0;
    // counter, pending patterns and group sequencing
    start_run();
    wr(0, 0, a0 + 4);
    rnd_cyc(a0);
    count_n(2);
    rnd_cyc(a0);
    count_n(1);
    rnd_cyc(a0);
    count_n(2);
    rnd_cyc(a0);
    act(0, 1'b1, 1'b0);
    act(1, 1'b0, 1'b1);
    count_n(2);
    rnd_cyc(a0);
    count_n(1);
    rnd_cyc(a0);
    act(2, 1'b1, 1'b1);
    rnd_cyc(a0);
    act(3, 1'b0, 1'b1);
    repeat (10) rnd_cyc($urandom & 32'hFFFFFFFC);
    start_run();
    rnd_cyc(a0 + 4);
    give_verdict();
  end
endmodule
